// ===== rtl/fbs_map.sv
// boot address, lock level decode, extra-array bytes and fetch steering
`default_nettype none
module fbs_map #(
	parameter logic [7:0] MAKER_ID  = 8'h11, // arbitrary value
	parameter logic [7:0] FAMILY_ID = 8'h22, // arbitrary value
	parameter logic [7:0] MEMORY_ID = 8'h33, // arbitrary value
	parameter logic [7:0] NAME_ID   = 8'h44, // arbitrary value
	parameter bit         SIZE_32K  = 1'b1
) (
	input  wire logic                clk,
	input  wire logic                sys_rst,
	input  wire logic                external_fetch_select,
	input  wire logic [15:0]         fetch_addr,
	input  wire logic                fetch_is_code_read,
	input  wire logic                fetch_from_external,
	input  wire logic                par_chip_erase,
	input  wire logic                par_prog_req,
	input  wire logic                par_verify_req,
	input  wire logic                par_hw_wr,
	input  wire logic [7:0]          par_hw_wdata,
	input  wire logic                xa_wr,
	input  wire logic                xa_rd,
	input  wire logic                xa_from_isp,
	input  wire logic [7:0]          xa_addr,
	input  wire logic [7:0]          xa_wdata,
	input  wire logic                isp_prog_req,
	input  wire logic                isp_verify_req,
	output logic [15:0]              boot_addr,
	output logic                     fetch_external,
	output logic                     fetch_denied,
	output logic                     par_prog_ok,
	output logic                     par_verify_ok,
	output logic                     isp_prog_ok,
	output logic                     isp_verify_ok,
	output logic                     flash_erase,
	output logic [7:0]               xa_rdata,
	output logic                     xa_rvalid,
	output logic [7:0]               hw_lock_byte,
	output fbs_pkg::fbs_level_t      hw_level,
	output fbs_pkg::fbs_level_t      soft_level,
	output logic                     double_speed_select,
	output logic [1:0]               osc_range_select
);
	import fbs_pkg::*;

	typedef struct packed {
		logic [7:0]  hw;
		logic [7:0]  boot_st;
		logic [7:0]  boot_vec;
		logic [7:0]  soft_lk;
		fbs_level_t  hw_lvl;
		fbs_level_t  sw_lvl;
		logic        ea_latch;
		logic        sampled;
		logic [15:0] boot;
		logic        f_ext;
		logic        f_deny;
		logic        p_prog;
		logic        p_ver;
		logic        i_prog;
		logic        i_ver;
		logic        erase;
		logic [7:0]  rdata;
		logic        rvalid;
	} fbs_state_t;

	fbs_state_t s_q;
	fbs_state_t s_d;

	function automatic fbs_level_t hw_decode(input logic [7:0] b);
		if (!b[FBS_BIT_LK_HIGH])     hw_decode = FBS_LVL4; // [RULE3]
		else if (!b[FBS_BIT_LK_MID]) hw_decode = FBS_LVL3; // [RULE3]
		else if (!b[FBS_BIT_LK_LOW]) hw_decode = FBS_LVL2;
		else                         hw_decode = FBS_LVL1;
	endfunction

	function automatic fbs_level_t sw_decode(input logic [7:0] b);
		// only bits 1-0 count; upper bits are software's to keep high
		if (!b[0] && !b[1]) sw_decode = FBS_LVL3; // [RULE15]
		else if (!b[0])     sw_decode = FBS_LVL2;
		else                sw_decode = FBS_LVL1;
	endfunction

	logic [15:0] top_addr;
	logic        above_top;
	logic        ext_pin;
	logic        wr_ok;

	always_comb begin
		s_d = s_q;
		top_addr  = SIZE_32K ? FBS_TOP_32K : FBS_TOP_16K; // [RULE17]
		s_d.rvalid = 1'b0;
		s_d.erase  = 1'b0;
		// one sample after reset release; held until the next reset or erase
		if (!s_q.sampled) begin
			s_d.sampled  = 1'b1;
			s_d.hw_lvl   = hw_decode(s_q.hw); // [RULE22]
			s_d.sw_lvl   = sw_decode(s_q.soft_lk); // [RULE22]
			s_d.ea_latch = external_fetch_select; // [RULE4]
			s_d.boot = s_q.hw[FBS_BIT_BOOT] ? FBS_BOOT_APP : FBS_BOOT_LOADER; // [RULE1] [RULE2]
		end
		// hardware levels gate parallel access only, software levels gate ISP
		s_d.p_prog = (s_d.hw_lvl == FBS_LVL1); // [RULE4] [RULE8]
		s_d.p_ver  = (s_d.hw_lvl == FBS_LVL1) || (s_d.hw_lvl == FBS_LVL2); // [RULE5]
		s_d.i_prog = (s_d.sw_lvl == FBS_LVL1); // [RULE13] [RULE8]
		s_d.i_ver  = (s_d.sw_lvl != FBS_LVL3); // [RULE14]
		ext_pin    = (s_q.hw_lvl == FBS_LVL1) ? external_fetch_select : s_q.ea_latch;
		above_top  = fetch_addr > top_addr;
		s_d.f_ext  = !ext_pin || above_top; // [RULE18] [RULE19]
		s_d.f_deny = ((s_q.hw_lvl != FBS_LVL1) && fetch_is_code_read && fetch_from_external
			&& !s_d.f_ext) // [RULE4]
			|| ((s_q.hw_lvl == FBS_LVL4) && s_d.f_ext); // [RULE6]
		if (par_chip_erase) begin
			s_d.hw     = FBS_HW_ERASED; // [RULE9]
			s_d.hw_lvl = FBS_LVL1; // [RULE9]
			s_d.erase  = 1'b1; // [RULE9]
			// erased byte is re-decoded next cycle, so boot and levels follow it
			s_d.sampled = 1'b0; // [RULE22]
		end else if (par_hw_wr) begin
			// programming only clears bits; levels and boot never follow it, as reset reloads FBS_HW_SHIPPED and erase loads FBS_HW_ERASED; clock selects at once
			s_d.hw = s_q.hw & par_hw_wdata; // [RULE21]
		end
		wr_ok = xa_from_isp ? s_q.i_prog : s_q.p_prog;
		if (xa_wr && wr_ok) begin
			if (xa_addr == FBS_OFF_BOOT_ST) begin
				s_d.boot_st = xa_wdata; // [RULE12]
			end else if (xa_addr == FBS_OFF_BOOT_VEC) begin
				s_d.boot_vec = xa_wdata;
			end else if (xa_addr == FBS_OFF_SOFT_LK) begin
				s_d.soft_lk = xa_wdata;
			end
		end
		if (xa_rd) begin
			s_d.rvalid = 1'b1;
			if (xa_addr == FBS_OFF_MAKER) begin
				s_d.rdata = MAKER_ID; // [RULE10]
			end else if (xa_addr == FBS_OFF_FAMILY) begin
				s_d.rdata = FAMILY_ID; // [RULE10]
			end else if (xa_addr == FBS_OFF_MEMORY) begin
				s_d.rdata = MEMORY_ID; // [RULE10]
			end else if (xa_addr == FBS_OFF_NAME) begin
				s_d.rdata = NAME_ID; // [RULE10]
			end else if (!(xa_from_isp ? s_q.i_ver : s_q.p_ver)) begin
				s_d.rdata = FBS_RST_BYTE;
			end else if (xa_addr == FBS_OFF_BOOT_ST) begin
				s_d.rdata = s_q.boot_st;
			end else if (xa_addr == FBS_OFF_BOOT_VEC) begin
				s_d.rdata = s_q.boot_vec;
			end else if (xa_addr == FBS_OFF_SOFT_LK) begin
				s_d.rdata = s_q.soft_lk;
			end else begin
				s_d.rdata = FBS_RST_BYTE;
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_q <= '{hw: FBS_HW_SHIPPED, boot_st: FBS_RST_BYTE, boot_vec: FBS_RST_BYTE, // [RULE7] [RULE11]
				soft_lk: FBS_RST_BYTE, hw_lvl: FBS_LVL4, sw_lvl: FBS_LVL1, ea_latch: 1'b1,
				sampled: 1'b0, boot: FBS_BOOT_LOADER, f_ext: 1'b0, f_deny: 1'b0, p_prog: 1'b0,
				p_ver: 1'b0, i_prog: 1'b0, i_ver: 1'b0, erase: 1'b0, rdata: 8'h00, rvalid: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	assign boot_addr           = s_q.boot;
	assign fetch_external      = s_q.f_ext;
	assign fetch_denied        = s_q.f_deny;
	assign par_prog_ok         = s_q.p_prog;
	assign par_verify_ok       = s_q.p_ver;
	assign isp_prog_ok         = s_q.i_prog;
	assign isp_verify_ok       = s_q.i_ver;
	assign flash_erase         = s_q.erase;
	assign xa_rdata            = s_q.rdata;
	assign xa_rvalid           = s_q.rvalid;
	assign hw_lock_byte        = s_q.hw;
	assign hw_level            = s_q.hw_lvl;
	assign soft_level          = s_q.sw_lvl;
	assign double_speed_select = s_q.hw[FBS_BIT_DBL]; // [RULE11]
	assign osc_range_select    = s_q.hw[FBS_BIT_OSC_HI:FBS_BIT_OSC_LO]; // [RULE11]
endmodule : fbs_map
`default_nettype wire

// ===== rtl/fbs_pkg.sv
// constants and types for the flash boot and security map
// Behaviour
// [RULE1] boot select one: start at 0000h
// [RULE2] boot select zero (shipped): start at F400h
// [RULE3] lock bits: one unprogrammed, higher bits override
// [RULE4] level 2: block code reads, parallel programming
// [RULE5] level 3: also refuse parallel verify reads
// [RULE6] level 4: also forbid external execution
// [RULE7] shipped hardware lock bits give level 4
// [RULE8] hardware locks govern parallel only; software locks ISP
// [RULE9] chip erase clears flash, restores inactive security byte
// [RULE10] part identification readable at every level
// [RULE11] shipped: double speed one, oscillator range ones
// [RULE12] programmer writes 00h to boot state after ISP
// [RULE13] software level 2 rejects ISP flash programming
// [RULE14] software level 3 also refuses ISP verify
// [RULE15] software keeps soft lock bits 7-2 at one
// [RULE16] parallel protection needs hardware byte programmed too
// [RULE17] internal flash fills lowest 16K or 32K
// [RULE18] external pin high: internal, external above top
// [RULE19] external pin low: every fetch external
// [RULE20] leave top internal location vacant
// [RULE21] boot select bit 6, locks 2-0, double speed 7
// [RULE22] security levels sampled at reset, held
`default_nettype none
package fbs_pkg;
	localparam logic [7:0]  FBS_HW_SHIPPED   = 8'hb8;
	localparam logic [7:0]  FBS_HW_ERASED    = 8'hff;
	localparam int          FBS_BIT_DBL      = 7;
	localparam int          FBS_BIT_BOOT     = 6;
	localparam int          FBS_BIT_OSC_HI   = 5;
	localparam int          FBS_BIT_OSC_LO   = 4;
	localparam int          FBS_BIT_LK_HIGH  = 2;
	localparam int          FBS_BIT_LK_MID   = 1;
	localparam int          FBS_BIT_LK_LOW   = 0;
	localparam logic [7:0]  FBS_OFF_BOOT_ST  = 8'h00;
	localparam logic [7:0]  FBS_OFF_BOOT_VEC = 8'h01;
	localparam logic [7:0]  FBS_OFF_SOFT_LK  = 8'h05;
	localparam logic [7:0]  FBS_OFF_MAKER    = 8'h30;
	localparam logic [7:0]  FBS_OFF_FAMILY   = 8'h31;
	localparam logic [7:0]  FBS_OFF_MEMORY   = 8'h60;
	localparam logic [7:0]  FBS_OFF_NAME     = 8'h61;
	localparam logic [7:0]  FBS_RST_BYTE     = 8'hff;
	localparam logic [15:0] FBS_BOOT_APP     = 16'h0000;
	localparam logic [15:0] FBS_BOOT_LOADER  = 16'hf400;
	localparam logic [15:0] FBS_TOP_16K      = 16'h3fff;
	localparam logic [15:0] FBS_TOP_32K      = 16'h7fff;
	typedef enum logic [1:0] {
		FBS_LVL1 = 2'b00,
		FBS_LVL2 = 2'b01,
		FBS_LVL3 = 2'b10,
		FBS_LVL4 = 2'b11
	} fbs_level_t;
endpackage : fbs_pkg
`default_nettype wire

// ===== verif/fbs_map_chk.sv
// port assertions for the flash boot and security map
`default_nettype none
module fbs_map_chk #(
	parameter logic [7:0] MAKER_ID = 8'h11,
	parameter bit         SIZE_32K = 1'b1
) (
	input wire logic                clk,
	input wire logic                sys_rst,
	input wire logic                external_fetch_select,
	input wire logic [15:0]         fetch_addr,
	input wire logic                par_chip_erase,
	input wire logic                xa_rd,
	input wire logic [7:0]          xa_addr,
	input wire logic                fetch_external,
	input wire logic                fetch_denied,
	input wire logic                par_prog_ok,
	input wire logic                par_verify_ok,
	input wire logic                flash_erase,
	input wire logic [7:0]          xa_rdata,
	input wire logic                xa_rvalid,
	input wire logic [7:0]          hw_lock_byte,
	input wire fbs_pkg::fbs_level_t hw_level,
	input wire logic                double_speed_select,
	input wire logic [1:0]          osc_range_select
);
	import fbs_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	erase_clear_a: assert property (par_chip_erase |=> flash_erase && hw_level == FBS_LVL1 && hw_lock_byte == 8'hff)
		else $error("chip erase did not clear security");
	id_read_a: assert property (xa_rd && xa_addr == 8'h30 |=> xa_rvalid && xa_rdata == MAKER_ID)
		else $error("maker copy not readable");
	par_prog_a: assert property (hw_level != FBS_LVL1 && $stable(hw_level) |-> !par_prog_ok)
		else $error("parallel programming open when locked");
	par_open_a: assert property (hw_level == FBS_LVL1 && $past(hw_level) == FBS_LVL1 |-> par_prog_ok && par_verify_ok)
		else $error("parallel access closed at level one");
	par_verify_a: assert property (hw_level inside {FBS_LVL3, FBS_LVL4} && $stable(hw_level) |-> !par_verify_ok)
		else $error("parallel verify open when locked");
	ext_top_a: assert property (hw_level == FBS_LVL1 && external_fetch_select |=>
		fetch_external == ($past(fetch_addr) > (SIZE_32K ? 16'h7fff : 16'h3fff)))
		else $error("fetch steering wrong with pin high");
	ext_low_a: assert property (hw_level == FBS_LVL1 && !external_fetch_select |=> fetch_external)
		else $error("fetch not external with pin low");
	lvl4_ext_a: assert property (hw_level == FBS_LVL4 && fetch_addr > 16'h7fff |=> fetch_denied)
		else $error("external execution allowed at level four");
	shipped_a: assert property (hw_lock_byte == 8'hb8 |-> hw_level == FBS_LVL4 && double_speed_select
		&& osc_range_select == 2'b11)
		else $error("shipped security byte decoded wrong");
endmodule // fbs_map_chk
bind fbs_map fbs_map_chk #(.MAKER_ID(MAKER_ID), .SIZE_32K(SIZE_32K)) u_chk (.*);
`default_nettype wire

// ===== verif/fbs_prog_model.sv
// programmer and isp party driving the extra-array and erase pins
`default_nettype none
module fbs_prog_model (
	input  wire logic [1:0] req,
	input  wire logic       isp,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] data,
	output logic            par_chip_erase,
	output logic            xa_rd,
	output logic            xa_wr,
	output logic            xa_from_isp,
	output logic [7:0]      xa_addr,
	output logic [7:0]      xa_wdata
);
	timeunit 1ns;
	timeprecision 1ns;
	import fbs_pkg::*;
	// req 3 drives chip erase, 1 an extra-array read, 2 an extra-array write
	assign par_chip_erase = req == 2'd3;
	assign xa_rd = req == 2'd1;
	assign xa_wr = req == 2'd2;
	assign xa_from_isp = isp;
	assign xa_addr = addr;
	// reserved soft lock bits are never cleared
	assign xa_wdata = addr == FBS_OFF_SOFT_LK ? data | 8'hfc : data;
endmodule // fbs_prog_model
`default_nettype wire

// ===== verif/test_fbs_map.sv
// self-checking bench for the flash boot and security map
`default_nettype none
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin errors++; $display("BAD %s exp %h got %h", n, e, s); end end
module test_fbs_map;
	timeunit 1ns;
	timeprecision 1ns;
	import fbs_pkg::*;
	logic clk = 0, sys_rst = 1, external_fetch_select = 1, fetch_is_code_read = 0, fetch_from_external = 0;
	logic par_prog_req = 0, par_verify_req = 0, isp_prog_req = 0, isp_verify_req = 0, par_hw_wr = 0, isp = 0;
	logic [15:0] fetch_addr = 0, boot_addr;
	logic [7:0] par_hw_wdata = 0, addr = 0, data = 0, xa_addr, xa_wdata, xa_rdata, hw_lock_byte, exp_b;
	logic [1:0] req = 0, osc_range_select;
	logic par_chip_erase, xa_rd, xa_wr, xa_from_isp, fetch_external, fetch_denied, par_prog_ok, par_verify_ok;
	logic isp_prog_ok, isp_verify_ok, flash_erase, xa_rvalid, double_speed_select;
	logic [31:0] r;
	fbs_level_t hw_level, soft_level;
	logic [7:0] expq[$];
	int errors = 0, num_checks = 0, seed = 32'hdca4715d;
	fbs_map dut (.*);
	fbs_prog_model u_prog (.*);
	initial forever #50 clk = ~clk;
	// for reads, d carries the byte expected back
	task automatic op(input logic [1:0] q, input logic i, input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		{req, isp, addr, data} = {q, i, a, d};
		if (q == 2'd1) expq.push_back(d);
		@(negedge clk);
		req = 2'd0;
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	always @(negedge clk) if (xa_rvalid === 1'b1) begin
		if (expq.size() == 0) `CHK("xa_rvalid", 1'b0, xa_rvalid)
		else begin
			exp_b = expq.pop_front();
			`CHK("xa_rdata", exp_b, xa_rdata)
		end
	end
	initial begin
		for (int k = 0; k < 2; k++) begin
			repeat (5) @(negedge clk);
			sys_rst = 0;
			repeat (2) @(negedge clk);
			`CHK("hw_level", FBS_LVL4, hw_level)
			`CHK("boot_addr", FBS_BOOT_LOADER, boot_addr)
			`CHK("hw_lock_byte", FBS_HW_SHIPPED, hw_lock_byte)
			`CHK("clock_cfg", 3'b111, {double_speed_select, osc_range_select})
			`CHK("par_ok", 2'b00, {par_prog_ok, par_verify_ok})
			`CHK("isp_ok", 2'b11, {isp_prog_ok, isp_verify_ok})
			if (k == 0) begin
				op(2'd1, 1'b1, FBS_OFF_SOFT_LK, FBS_RST_BYTE);
				op(2'd1, 1'b1, 8'h7f, 8'hff);
				op(2'd2, 1'b0, FBS_OFF_BOOT_VEC, 8'h12);
				op(2'd1, 1'b1, FBS_OFF_BOOT_VEC, FBS_RST_BYTE);
				op(2'd2, 1'b1, FBS_OFF_BOOT_ST, 8'h00);
				op(2'd1, 1'b1, FBS_OFF_BOOT_ST, 8'h00);
				op(2'd1, 1'b0, FBS_OFF_BOOT_ST, FBS_RST_BYTE);
				op(2'd1, 1'b0, FBS_OFF_MAKER, 8'h11);
				op(2'd1, 1'b0, FBS_OFF_FAMILY, 8'h22);
				op(2'd1, 1'b1, FBS_OFF_MEMORY, 8'h33);
				op(2'd1, 1'b0, FBS_OFF_NAME, 8'h44);
				{fetch_is_code_read, fetch_from_external, fetch_addr} = {2'b11, 16'h0100};
				@(negedge clk);
				`CHK("fetch_denied", 1'b1, fetch_denied)
				{fetch_is_code_read, fetch_from_external, fetch_addr} = {2'b00, 16'h9000};
				@(negedge clk);
				`CHK("fetch_denied", 1'b1, fetch_denied)
				fetch_addr = 16'h0000;
				op(2'd2, 1'b1, FBS_OFF_SOFT_LK, 8'h00);
				op(2'd3, 1'b0, 8'h00, 8'h00);
				`CHK("erase", {1'b1, FBS_LVL1, FBS_HW_ERASED}, {flash_erase, hw_level, hw_lock_byte})
				@(negedge clk);
				`CHK("par_ok", 2'b11, {par_prog_ok, par_verify_ok})
				`CHK("boot_addr", FBS_BOOT_APP, boot_addr)
				`CHK("soft_level", FBS_LVL3, soft_level)
				`CHK("isp_ok", 2'b00, {isp_prog_ok, isp_verify_ok})
				op(2'd1, 1'b1, FBS_OFF_BOOT_ST, FBS_RST_BYTE);
				op(2'd2, 1'b1, FBS_OFF_BOOT_VEC, 8'h12);
				op(2'd1, 1'b0, FBS_OFF_BOOT_VEC, FBS_RST_BYTE);
				repeat (40) begin
					r = $random(seed);
					{external_fetch_select, fetch_addr} = r[16:0];
					@(negedge clk);
					`CHK("fetch_ext", !external_fetch_select || fetch_addr > FBS_TOP_32K, fetch_external)
					`CHK("fetch_denied", 1'b0, fetch_denied)
				end
				{par_hw_wr, par_hw_wdata} = {1'b1, 8'hbf};
				@(negedge clk);
				`CHK("hw_write", 8'hbf, hw_lock_byte)
				{par_hw_wr, sys_rst} = 2'b01;
			end
		end
		repeat (10) if (expq.size() != 0) @(negedge clk);
		if (expq.size() != 0) errors++;
		tally_and_finish();
	end
endmodule // test_fbs_map
`default_nettype wire
